// ---- src/ferx_rx_path.sv ----
// Receive decode path with its nibble FIFO
`timescale 1ns/1ps
`default_nettype none

module ferx_fifo
   import ferx_pkg::*;
#(
   parameter int W     = 6,
   parameter int DEPTH = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
   } ferx_fst_t;

   ferx_fst_t s;
   ferx_fst_t n;
   logic      doW;
   logic      doR;

   // Honest full and empty
   assign inReady  = (s.cnt != (AW+1)'(DEPTH));
   assign outValid = (s.cnt != '0);
   assign outData  = s.mem[s.rp];

   // Pointer and count update
   always_comb begin
      n   = s;
      doW = inValid && inReady;
      doR = outValid && outReady;
      if (doW) begin
         n.mem[s.wp] = inData;
         n.wp = (s.wp == AW'(DEPTH-1)) ? '0 : s.wp + 1'b1;
      end
      if (doR) begin
         n.rp = (s.rp == AW'(DEPTH-1)) ? '0 : s.rp + 1'b1;
      end
      n.cnt = s.cnt + (AW+1)'(doW) - (AW+1)'(doR);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end
endmodule

module ferx_rx_path
   import ferx_pkg::*;
#(
   parameter int NPH  = NUM_PH,
   parameter int WDOG = WDOG_CYC,
   parameter int FDEP = 8
) (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic [NPH-1:0][SAMP_W-1:0] phaseSamples,
   input  wire logic [$clog2(NPH)-1:0]     phaseSel,
   input  wire logic                       sampleStb,
   input  wire logic                       linkOk,
   input  wire logic                       lineSignalPresent,
   output logic                            rxClk,
   output logic [3:0]                      rxd,
   output logic                            rxDv,
   output logic                            rxEr,
   output logic                            crs,
   output logic                            descrLocked
);
   localparam int WW = $clog2(WDOG) + 1;
   localparam int A_DIV = MII_DIV;

   typedef struct packed {
      ferx_lvl_t        lvl;
      logic             nrzi;
      logic [KEY_W-1:0] key;
      logic [6:0]       ones;
      logic             locked;
      logic [WW-1:0]    wdog;
      logic [9:0]       sh;
      logic [2:0]       ph5;
      logic [2:0]       div;
      ferx_st_t         st;
      logic             idlePend;
      ferx_word_t       w;
      logic             wV;
      logic             pend2;
      logic             newW;
      logic             grpQ;
      logic             tick;
      ferx_mii_t        mii;
   } ferx_state_t;

   ferx_state_t s;
   ferx_state_t n;

   logic       fInReady;
   logic       fOutValid;
   ferx_word_t fOut;
   logic       codeBit;
   logic       sBit;
   logic       dBit;
   logic       pk;
   logic       grpDone;
   logic [4:0] grp;
   logic [4:0] dec;
   logic       abort;
   logic       refMode;

   // Signed sample to three line levels
   function automatic ferx_lvl_t slice(input logic [SAMP_W-1:0] v);
      if ($signed(v) > SLICE_TH) begin
         slice = LVL_P;
      end else if ($signed(v) < -SLICE_TH) begin
         slice = LVL_N;
      end else begin
         slice = LVL_Z;
      end
   endfunction

   // Word queued toward the MII side
   function automatic ferx_word_t mkw(input logic dv, input logic er,
                                      input logic [3:0] nib);
      mkw = '{dv: dv, er: er, nib: nib};
   endfunction

   ferx_fifo #(
      .W     ($bits(ferx_word_t)),
      .DEPTH (FDEP)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (s.wV),
      .inReady  (fInReady),
      .inData   (s.w),
      .outValid (fOutValid),
      .outReady (s.tick),
      .outData  (fOut)
   );

   // Whole receive path next state
   always_comb begin
      n        = s;
      n.newW   = 1'b0;
      n.grpQ   = 1'b0;
      n.tick   = 1'b0;
      codeBit  = 1'b0;
      sBit     = 1'b0;
      dBit     = 1'b0;
      grpDone  = 1'b0;
      pk       = s.key[KEY_W-1] ^ s.key[KEY_W-3];
      abort    = !linkOk || !lineSignalPresent;
      refMode  = !lineSignalPresent || !s.locked;

      // Queued word leaves when the FIFO takes it
      if (s.wV && fInReady) begin
         n.wV = 1'b0;
      end

      // Second SSD nibble waits for room
      if (s.pend2 && !n.wV) begin
         n.w     = mkw(1'b1, 1'b0, NIB_SSD); // [R14]
         n.wV    = 1'b1;
         n.newW  = 1'b1;
         n.pend2 = 1'b0;
      end

      // One recovered bit per selected sample
      if (sampleStb) begin
         n.lvl   = slice(phaseSamples[phaseSel]); // [R1] [R2]
         codeBit = (n.lvl != s.lvl); // [R4]
         n.nrzi  = s.nrzi ^ codeBit; // [R3]
         sBit    = n.nrzi ^ s.nrzi; // [R5]
         dBit    = sBit ^ pk; // [R6]
         // Self-sync on IDLE until locked, then free run
         n.key   = {s.key[KEY_W-2:0], s.locked ? pk : ~sBit}; // [R7]
         if (!dBit) begin
            n.ones = '0;
         end else if (s.ones != 7'h7F) begin
            n.ones = s.ones + 7'h01;
         end
         if (!s.locked && s.ones >= LOCK_ONES) begin
            n.locked = 1'b1; // [R7]
         end
         n.sh  = {s.sh[8:0], dBit}; // [R6]
         n.ph5 = (s.ph5 == 3'h4) ? 3'h0 : s.ph5 + 3'h1;
         if (s.st == ST_HUNT && s.locked &&
             {s.sh[8:0], dBit} == CG_IJ) begin
            n.ph5 = 3'h0; // [R10] [R12]
            n.st  = ST_SSDK;
         end
         grpDone = (s.st != ST_HUNT) && (s.ph5 == 3'h4); // [R11]
      end
      grp = n.sh[4:0];
      dec = ferx_dec5(grp);

      // Code group handling
      if (grpDone) begin
         n.grpQ = 1'b1;
         unique case (s.st)
            ST_SSDK: begin
               if (grp == CG_K) begin
                  n.w     = mkw(1'b1, 1'b0, NIB_SSD); // [R14] [R15]
                  n.pend2 = 1'b1;
                  n.st    = ST_FRAME;
               end else begin
                  n.w  = mkw(1'b0, 1'b1, NIB_BAD); // [R22]
                  n.st = ST_HUNT;
               end
               n.wV   = 1'b1;
               n.newW = 1'b1;
            end
            ST_FRAME: begin
               if (grp == CG_I && s.idlePend) begin
                  n.st       = ST_HUNT; // [R16]
                  n.idlePend = 1'b0;
               end else if (grp == CG_I) begin
                  n.idlePend = 1'b1; // [R17]
               end else if (grp == CG_T && !s.idlePend) begin
                  n.st = ST_ESDR; // [R17]
               end else begin
                  // Lone IDLE or non-data gives an error nibble
                  n.w = mkw(1'b1, !dec[4] || s.idlePend,
                            dec[3:0]); // [R13] [R20] [R21]
                  n.wV       = 1'b1;
                  n.newW     = 1'b1;
                  n.idlePend = 1'b0;
               end
            end
            ST_ESDR: begin
               if (grp != CG_R) begin
                  n.w    = mkw(1'b1, 1'b1, NIB_BAD); // [R20]
                  n.wV   = 1'b1;
                  n.newW = 1'b1;
               end
               n.st = ST_HUNT; // [R16]
            end
            default: begin
               n.st = ST_HUNT;
            end
         endcase
      end

      // Overrun marks the replacing word as errored
      if (n.newW && s.wV && !fInReady) begin
         n.w.er = 1'b1;
      end

      // IDLE watchdog, 40 us by default, shorter than a full 1514-byte frame
      if (!s.locked || s.ones >= IDLE_RUN) begin
         n.wdog = '0; // [R9]
      end else begin
         n.wdog = s.wdog + WW'(1);
      end
      if (s.locked && s.wdog == WW'(WDOG - 1)) begin
         n.locked = 1'b0; // [R8]
         n.wdog   = '0;
      end

      // Abort any frame on loss of lock or link
      if (!n.locked || abort) begin
         n.st       = ST_HUNT; // [R8] [R18]
         n.idlePend = 1'b0;
         n.pend2    = 1'b0;
      end

      // Receive clock from recovered bits or reference
      if (refMode) begin
         n.div       = (s.div == 3'(MII_DIV - 1)) ? 3'h0
                                                  : s.div + 3'h1;
         n.mii.rxClk = (n.div < 3'(MII_HALF)); // [R24]
         n.tick      = (s.div == 3'(MII_HALF - 1));
      end else begin
         n.div       = '0;
         n.mii.rxClk = (n.ph5 < 3'h3); // [R23]
         n.tick      = sampleStb && (s.ph5 == 3'h2);
      end

      // Drain one word per falling receive clock
      if (s.tick) begin
         if (fOutValid) begin
            n.mii.rxd  = fOut.nib; // [R19]
            n.mii.rxDv = fOut.dv; // [R15]
            n.mii.rxEr = fOut.er; // [R20] [R22]
            n.mii.crs  = fOut.dv; // [R26]
         end else begin
            n.mii.rxd  = '0;
            n.mii.rxDv = 1'b0; // [R16]
            n.mii.rxEr = 1'b0;
            n.mii.crs  = 1'b0; // [R16]
         end
      end
      if (abort) begin
         n.mii.rxDv = 1'b0; // [R18]
         n.mii.crs  = 1'b0;
      end
   end

   // Single state register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s     <= '0;
         s.st  <= ST_HUNT;
         s.key <= KEY_RST;
      end else begin
         s <= n;
      end
   end

   // Outputs straight from state flops
   assign rxClk       = s.mii.rxClk;
   assign rxd         = s.mii.rxd;
   assign rxDv        = s.mii.rxDv;
   assign rxEr        = s.mii.rxEr;
   assign crs         = s.mii.crs;
   assign descrLocked = s.locked;

   // Delimiter steps
   sequence sKGroup;
      s.st == ST_SSDK && grpDone && grp == CG_K;
   endsequence

   sequence sBadGroup;
      s.st == ST_SSDK && grpDone && grp != CG_K;
   endsequence

   sequence sTwoSsdNibbles;
      s.newW && s.w.nib == NIB_SSD && s.w.dv ##[1:8]
         (s.newW && s.w.nib == NIB_SSD && s.w.dv);
   endsequence

   a_ssd_pair: assert property ( // [R14]
      @(posedge clk) disable iff (!rst_n)
      sKGroup ##0 (linkOk && lineSignalPresent) ##1 fInReady
      |-> sTwoSsdNibbles)
      else $error("SSD did not yield two 0101 nibbles");

   a_bad_ssd: assert property ( // [R22]
      @(posedge clk) disable iff (!rst_n)
      sBadGroup |=> s.newW && s.w.er && !s.w.dv &&
                   s.w.nib == NIB_BAD && s.st == ST_HUNT)
      else $error("bad SSD not flagged with 1110");

   a_idle_hidden: assert property ( // [R17]
      @(posedge clk) disable iff (!rst_n)
      s.st == ST_FRAME && grpDone && grp == CG_I && !s.pend2
      |=> !s.newW)
      else $error("IDLE group produced a nibble");

   a_two_idle_end: assert property ( // [R16]
      @(posedge clk) disable iff (!rst_n)
      s.st == ST_FRAME && s.idlePend && grpDone && grp == CG_I
      |=> s.st == ST_HUNT)
      else $error("two IDLEs did not end the frame");

   a_invalid_err: assert property ( // [R21]
      @(posedge clk) disable iff (!rst_n)
      s.st == ST_FRAME && grpDone && !s.pend2 &&
      (grp == 5'h06 || grp == 5'h19)
      |=> s.newW && s.w.er && s.w.dv)
      else $error("invalid group not flagged");

   a_link_drop: assert property ( // [R18]
      @(posedge clk) disable iff (!rst_n)
      !linkOk || !lineSignalPresent |=> !rxDv && !crs)
      else $error("valid held after link loss");

   a_wdog_abort: assert property ( // [R8]
      @(posedge clk) disable iff (!rst_n)
      s.locked && s.wdog == WW'(WDOG - 1)
      |=> !s.locked && s.st == ST_HUNT)
      else $error("watchdog did not restart sync");

   a_ref_rate: assert property ( // [R24]
      @(posedge clk) disable iff (!rst_n)
      s.tick && refMode && s.div == 3'(MII_HALF)
      |-> ##A_DIV (s.tick || !refMode || $past(!refMode))
      ) else $error("reference receive clock off rate");

   a_drain_out: assert property ( // [R19]
      @(posedge clk) disable iff (!rst_n)
      s.tick && fOutValid && !abort
      |=> rxd == $past(fOut.nib) && rxDv == $past(fOut.dv) &&
          crs == rxDv)
      else $error("nibble not driven from FIFO head");
endmodule

`default_nettype wire

// ---- src/ferx_pkg.sv ----
// Constants, types and code table of the 100BASE-TX receive path
// Contract
// R1 - Accept one 6-bit sample per sample period
// R2 - Timing unit selects the optimum sampling phase
// R3 - Convert three-level symbols into serial NRZI stream
// R4 - Level change reads one, no change zero
// R5 - NRZI bit differing from previous gives one
// R6 - Inverse scrambling, serial to 5-bit words
// R7 - Sync key on IDLE, then hold it
// R8 - No IDLE within window: abort, resync key
// R9 - Window passes a 1514-byte frame untouched; the default 40 us window is shorter than such a frame
// R10 - Align code groups on J then K
// R11 - Keep alignment until next start of frame
// R12 - J is 11000, K is 10001
// R13 - Data groups map to nibbles on bus
// R14 - Delimiter pair gives nibbles 0101 0101
// R15 - Valid rises with first delimiter nibble
// R16 - T-R or two IDLEs end carrier, valid
// R17 - End delimiter and IDLE give no nibbles
// R18 - Link failure or signal loss drops valid
// R19 - Nibbles driven with receive clock while valid
// R20 - Unexpected group in frame raises receive error
// R21 - Groups 00110, 11001 in frame raise error
// R22 - Bad delimiter: error, nibble 1110, no valid
// R23 - Nibbles leave at 25 MHz on recovered clock
// R24 - Without signal, clock comes from reference
// R25 - MAC samples on clock, discards errored frames; the model only flags them
// R26 - Carrier rises with valid, ends with frame
package ferx_pkg;

   // Clock and timing
   localparam int CLK_MHZ   = 200;
   localparam int MII_MHZ   = 25;
   localparam int MII_DIV   = CLK_MHZ / MII_MHZ;
   localparam int MII_HALF  = MII_DIV / 2;
   localparam int WDOG_US   = 40;
   localparam int WDOG_CYC  = WDOG_US * CLK_MHZ;

   // Sample and slicer
   localparam int SAMP_W    = 6;
   localparam int NUM_PH    = 4;
   localparam logic signed [SAMP_W-1:0] SLICE_TH = 6'sh10;

   // Descrambler
   localparam int KEY_W     = 11;
   localparam logic [KEY_W-1:0] KEY_RST = 11'h7FF;
   localparam logic [6:0] LOCK_ONES = 7'h3C;
   localparam logic [6:0] IDLE_RUN  = 7'h0A;

   // Code groups, first bit on the line is the MSB
   localparam logic [4:0] CG_J = 5'h18;
   localparam logic [4:0] CG_K = 5'h11;
   localparam logic [4:0] CG_T = 5'h0D;
   localparam logic [4:0] CG_R = 5'h07;
   localparam logic [4:0] CG_I = 5'h1F;
   localparam logic [9:0] CG_IJ = 10'h3F8;
   localparam logic [3:0] NIB_SSD = 4'h5;
   localparam logic [3:0] NIB_BAD = 4'hE;

   // Line levels
   typedef logic [1:0] ferx_lvl_t;
   localparam ferx_lvl_t LVL_Z = 2'h0;
   localparam ferx_lvl_t LVL_P = 2'h1;
   localparam ferx_lvl_t LVL_N = 2'h3;

   typedef enum logic [3:0] {
      ST_HUNT  = 4'h1,
      ST_SSDK  = 4'h2,
      ST_FRAME = 4'h4,
      ST_ESDR  = 4'h8
   } ferx_st_t;

   typedef struct packed {
      logic       dv;
      logic       er;
      logic [3:0] nib;
   } ferx_word_t;

   typedef struct packed {
      logic       rxClk;
      logic [3:0] rxd;
      logic       rxDv;
      logic       rxEr;
      logic       crs;
   } ferx_mii_t;

   // Five-bit data group to {valid, nibble}
   function automatic logic [4:0] ferx_dec5(input logic [4:0] g);
      unique case (g)
         5'h1E: ferx_dec5 = 5'h10;
         5'h09: ferx_dec5 = 5'h11;
         5'h14: ferx_dec5 = 5'h12;
         5'h15: ferx_dec5 = 5'h13;
         5'h0A: ferx_dec5 = 5'h14;
         5'h0B: ferx_dec5 = 5'h15;
         5'h0E: ferx_dec5 = 5'h16;
         5'h0F: ferx_dec5 = 5'h17;
         5'h12: ferx_dec5 = 5'h18;
         5'h13: ferx_dec5 = 5'h19;
         5'h16: ferx_dec5 = 5'h1A;
         5'h17: ferx_dec5 = 5'h1B;
         5'h1A: ferx_dec5 = 5'h1C;
         5'h1B: ferx_dec5 = 5'h1D;
         5'h1C: ferx_dec5 = 5'h1E;
         5'h1D: ferx_dec5 = 5'h1F;
         default: ferx_dec5 = 5'h00;
      endcase
   endfunction

endpackage

// ---- verif/ferx_mac_model.sv ----
// MAC-side receiver model of the internal nibble interface
`timescale 1ns/1ps
`default_nettype none

module ferx_mac_model
   import ferx_pkg::*;
(
   input  wire ferx_mii_t mii
);
   logic [3:0] nibQ [$];
   logic       errSeen    = 1'b0;
   logic       errNoDv    = 1'b0;
   logic [3:0] lastErrNib = 4'h0;
   int         crsBad     = 0;

   // Sample on the receive clock, flag frames that carried an error
   always @(posedge mii.rxClk) begin
      if (mii.crs !== mii.rxDv)
         crsBad++;
      if (mii.rxDv) begin
         nibQ.push_back(mii.rxd);
         if (mii.rxEr)
            errSeen = 1'b1;  // frame flagged as errored, nibbles still queued
      end else if (mii.rxEr) begin
         errNoDv = 1'b1;
         lastErrNib = mii.rxd;
      end
   end
endmodule

`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking bench for the receive decode path and its FIFO
`timescale 1ns/1ps
`default_nettype none

module tb
   import ferx_pkg::*;
;
   localparam int WD = 400;
   localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A,
      5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B,
      5'h1C, 5'h1D};

   logic                          clk = 1'b0;
   logic                          rst_n = 1'b0;
   logic [NUM_PH-1:0][SAMP_W-1:0] phaseSamples = '0;
   logic [$clog2(NUM_PH)-1:0]     phaseSel = '0;
   logic [$clog2(NUM_PH)-1:0]     selReq = '0;
   logic                          sampleStb = 1'b0;
   logic                          linkOk = 1'b1;
   logic                          lineSignalPresent = 1'b1;
   logic                          rxClk, rxDv, rxEr, crs, descrLocked;
   logic [3:0]                    rxd;
   ferx_mii_t                     mii;
   logic [10:0]                   txKey = 11'h5A3;
   logic [1:0]                    mltIdx = 2'h0;
   int                            gapCyc = 0;
   int                            bad_count = 0, total_checks = 0;

   always #2.5 clk = ~clk;

   // Receive path with a shortened watchdog and the MAC model
   ferx_rx_path #(.NPH(NUM_PH), .WDOG(WD), .FDEP(8)) i_dut (
      .clk(clk), .rst_n(rst_n), .phaseSamples(phaseSamples),
      .phaseSel(phaseSel), .sampleStb(sampleStb), .linkOk(linkOk),
      .lineSignalPresent(lineSignalPresent), .rxClk(rxClk), .rxd(rxd),
      .rxDv(rxDv), .rxEr(rxEr), .crs(crs), .descrLocked(descrLocked));
   assign mii = '{rxClk, rxd, rxDv, rxEr, crs};
   ferx_mac_model i_mac (.mii(mii));

   function automatic logic [SAMP_W-1:0] lvl(input logic [1:0] i);
      return (i == 2'h1) ? 6'h18 : (i == 2'h3) ? 6'h28 : 6'h00;
   endfunction

   // Scramble, three-level line code, wrong level on unselected phases
   task automatic send_bit(input logic b);
      logic s;
      s = txKey[10] ^ txKey[8];
      txKey = {txKey[9:0], s};
      // Optional idle cycles between samples
      repeat (gapCyc) begin
         @(negedge clk);
         sampleStb = 1'b0;
      end
      @(negedge clk);
      phaseSel = selReq;
      if (b ^ s)
         mltIdx = mltIdx + 2'h1;
      for (int p = 0; p < NUM_PH; p++)
         phaseSamples[p] = (p == phaseSel) ? lvl(mltIdx) : lvl(mltIdx + 2'h1);
      sampleStb = 1'b1;
   endtask

   task automatic send_grp(input logic [4:0] g);
      for (int i = 4; i >= 0; i--)
         send_bit(g[i]);
   endtask

   task automatic idles(input int n);
      repeat (n) send_grp(CG_I);
   endtask

   task automatic send_list(input logic [4:0] gs [$]);
      foreach (gs[i])
         send_grp(gs[i]);
   endtask

   task automatic stb_off();
      @(negedge clk);
      sampleStb = 1'b0;
   endtask

   task automatic fail(input string what);
      bad_count++;
      $display("[FAIL] %0t %s", $time, what);
   endtask

   task automatic chk_bit(input string what, input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
         fail(what);
   endtask

   task automatic chk_val(input string what, input logic [7:0] got,
                          input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
         fail(what);
   endtask

   task automatic clr();
      i_mac.nibQ.delete();
      i_mac.errSeen = 1'b0;
      i_mac.errNoDv = 1'b0;
   endtask

   task automatic chk_frame(input logic [3:0] e [$], input logic expErr);
      chk_val("nibble count", 8'(i_mac.nibQ.size()), 8'(e.size()));
      foreach (e[i])
         if (i < i_mac.nibQ.size())
            chk_val("nibble", {4'h0, i_mac.nibQ[i]}, {4'h0, e[i]});
      chk_bit("frame error flag", i_mac.errSeen, expErr);
   endtask

   // Rising edges of the receive clock over n cycles
   task automatic cnt_rise(input int n, output int c);
      logic prev;
      c = 0;
      prev = rxClk;
      repeat (n) begin
         @(negedge clk);
         if (rxClk && !prev)
            c++;
         prev = rxClk;
      end
   endtask

   task automatic t_lock();
      int c;
      idles(60);
      chk_bit("lock on idle", descrLocked, 1'b1);
      fork
         idles(16);
         cnt_rise(80, c);
      join
      chk_val("recovered clock", 8'(c), 8'h10);
      $display("test lock finished");
   endtask

   task automatic t_long_frame();
      logic [4:0] q [$];
      logic [3:0] e [$];
      selReq = 2'h2;
      q = {CG_J, CG_K};
      e = {NIB_SSD, NIB_SSD};
      for (int i = 0; i < 64; i++) begin
         q.push_back(ENC[i % 16]);
         e.push_back(4'(i % 16));
      end
      q.push_back(CG_T);
      q.push_back(CG_R);
      clr();
      send_list(q);
      idles(4);
      chk_frame(e, 1'b0);
      chk_bit("lock kept", descrLocked, 1'b1);
      chk_val("carrier", 8'(i_mac.crsBad), 8'h00);
      chk_bit("valid ends", rxDv, 1'b0);
      $display("test long frame finished");
   endtask

   task automatic t_short_frames();
      selReq = 2'h1;
      clr();
      send_list({CG_J, CG_K, ENC[3], ENC[12], CG_I, CG_I});
      idles(3);
      chk_frame({NIB_SSD, NIB_SSD, 4'h3, 4'hC}, 1'b0);
      clr();
      send_list({CG_J, CG_K, ENC[1], 5'h06, ENC[2], 5'h19, CG_T, CG_R});
      idles(3);
      chk_bit("invalid groups", i_mac.errSeen, 1'b1);
      clr();
      send_list({CG_J, ENC[5], ENC[6]});
      idles(4);
      chk_bit("bad start error", i_mac.errNoDv, 1'b1);
      chk_val("bad start nibble", {4'h0, i_mac.lastErrNib}, 8'h0E);
      chk_val("no valid", 8'(i_mac.nibQ.size()), 8'h00);
      $display("test short frames finished");
   endtask

   task automatic t_drop();
      int c;
      for (int k = 0; k < 2; k++) begin
         clr();
         send_list({CG_J, CG_K, ENC[7], ENC[8], ENC[9]});
         stb_off();
         chk_bit("valid up", rxDv, 1'b1);
         if (k == 0)
            lineSignalPresent = 1'b0;
         else
            linkOk = 1'b0;
         repeat (2) @(negedge clk);
         chk_bit("valid drops", rxDv, 1'b0);
         chk_bit("carrier drops", crs, 1'b0);
         if (k == 0) begin
            cnt_rise(80, c);
            chk_val("reference clock", 8'(c), 8'h0A);
         end
         lineSignalPresent = 1'b1;
         linkOk = 1'b1;
         idles(60);
      end
      $display("test signal drop finished");
   endtask

   task automatic t_watchdog();
      logic [4:0] q [$];
      q = {CG_J, CG_K};
      for (int i = 0; i < 120; i++)
         q.push_back(ENC[i % 16]);
      send_list(q);
      chk_bit("unlock", descrLocked, 1'b0);
      chk_bit("abort", rxDv, 1'b0);
      idles(60);
      chk_bit("relock", descrLocked, 1'b1);
      $display("test watchdog finished");
   endtask

   // Sparse strobes through the nibble FIFO, then T without R
   task automatic t_fifo();
      logic [4:0] q [$];
      logic [3:0] e [$];
      q = {CG_J, CG_K};
      e = {NIB_SSD, NIB_SSD};
      for (int i = 0; i < 16; i++) begin
         q.push_back(ENC[i]);
         e.push_back(4'(i));
      end
      q.push_back(CG_T);
      q.push_back(CG_R);
      gapCyc = 1;
      clr();
      send_list(q);
      idles(4);
      chk_frame(e, 1'b0);
      chk_bit("fifo empty", i_dut.fOutValid, 1'b0);
      chk_bit("valid after gaps", rxDv, 1'b0);
      gapCyc = 0;
      clr();
      send_list({CG_J, CG_K, ENC[4], CG_T, ENC[2]});
      idles(4);
      e = {NIB_SSD, NIB_SSD, 4'h4, NIB_BAD};
      chk_frame(e, 1'b1);
      $display("test fifo finished");
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (6) @(negedge clk);
      chk_val("reset values", {rxd, rxDv, rxEr, crs, descrLocked}, 8'h00);
      rst_n = 1'b1;
      t_lock();
      t_long_frame();
      t_short_frames();
      t_drop();
      t_watchdog();
      t_fifo();
      stop_test();
   end

   initial begin
      #100000;
      fail("watchdog expired");
      stop_test();
   end
endmodule

`default_nettype wire
